// ---- dge_pkg_buf.sv ----
// ----------------------------------------------------------------
// shared constants and types
// ----------------------------------------------------------------
package dge_pkg;
	// register bus
	localparam int          ADDR_W      = 4;
	localparam int          DATA_W      = 32;
	localparam logic [3:0]  REG_CFG     = 4'h0;
	localparam logic [3:0]  REG_STAT    = 4'h4;
	localparam logic [3:0]  REG_WORD    = 4'h8;
	localparam logic [31:0] CFG_RESET   = 32'h0000_0004;
	// configuration field positions
	localparam int          F_MODE_LO   = 0;
	localparam int          F_IN_REG    = 3;
	localparam int          F_IN_DDR_LO = 4;
	localparam int          F_IN_INV    = 6;
	localparam int          F_OREG_LO   = 7;
	localparam int          F_OUT_DDR_LO = 9;
	localparam int          F_OUT_INV   = 11;
	localparam int          F_OE_REG    = 12;
	localparam int          F_CONN_LO   = 13;
	// status field positions
	localparam int          S_OVERRUN   = 0;
	localparam int          S_CFG_ERR   = 1;
	localparam int          S_PAD       = 2;
	localparam int          S_FULL      = 3;
	// synchroniser lanes
	localparam int          L_PAD       = 0;
	localparam int          L_CAP       = 1;
	localparam int          L_LAUNCH    = 2;
	localparam int          N_LANES     = 3;

	typedef enum logic [2:0] {
		DGE_MODE_IN     = 3'h0,
		DGE_MODE_OUT    = 3'h1,
		DGE_MODE_BIDIR  = 3'h2,
		DGE_MODE_CLKOUT = 3'h3,
		DGE_MODE_UNUSED = 3'h4
	} dge_mode_t;

	typedef enum logic [1:0] {
		DGE_DDR_NONE    = 2'h0,
		DGE_DDR_NORMAL  = 2'h1,
		DGE_DDR_REALIGN = 2'h2
	} dge_ddr_t;

	typedef enum logic [1:0] {
		DGE_OREG_NONE   = 2'h0,
		DGE_OREG_PLAIN  = 2'h1,
		DGE_OREG_INV    = 2'h2
	} dge_oreg_t;

	typedef enum logic [2:0] {
		DGE_CONN_NORMAL = 3'h0,
		DGE_CONN_GCLK   = 3'h1,
		DGE_CONN_GCTRL  = 3'h2,
		DGE_CONN_PLLREF = 3'h3,
		DGE_CONN_PLLFB  = 3'h4,
		DGE_CONN_MIPI   = 3'h5
	} dge_conn_t;
endpackage : dge_pkg

// ----------------------------------------------------------------
// two-entry buffer, outputs straight from flops
// ----------------------------------------------------------------
module dge_buf2 #(
	parameter int W = 2
) (
	// clock and reset
	input  wire logic         ref_clk,
	input  wire logic         arst_n,
	// fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	logic         head_v_reg, head_v_next;
	logic         tail_v_reg, tail_v_next;
	logic [W-1:0] head_reg,   head_next;
	logic [W-1:0] tail_reg,   tail_next;
	logic         pop;
	logic         push;

	always_comb begin
		pop         = head_v_reg & out_ready;
		push        = in_valid & ~tail_v_reg;
		head_v_next = head_v_reg;
		tail_v_next = tail_v_reg;
		head_next   = head_reg;
		tail_next   = tail_reg;
		if (pop) begin
			if (tail_v_reg) begin
				head_next   = tail_reg;
				tail_v_next = 1'b0;
			end else if (push) begin
				head_next = in_data;
			end else begin
				head_v_next = 1'b0;
			end
		end else if (push) begin
			if (!head_v_reg) begin
				head_v_next = 1'b1;
				head_next   = in_data;
			end else begin
				tail_v_next = 1'b1;
				tail_next   = in_data;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			head_v_reg <= 1'b0;
			tail_v_reg <= 1'b0;
			head_reg   <= '0;
			tail_reg   <= '0;
		end else begin
			head_v_reg <= head_v_next;
			tail_v_reg <= tail_v_next;
			head_reg   <= head_next;
			tail_reg   <= tail_next;
		end
	end

	assign in_ready  = ~tail_v_reg;
	assign out_valid = head_v_reg;
	assign out_data  = head_reg;
endmodule : dge_buf2

// ---- dge_cell.sv ----
module dge_cell
	import dge_pkg::*;
(
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              arst_n,
	// register port
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [DATA_W-1:0]      reg_rdata,
	// core clocks from fabric
	input  wire logic              capture_clock,
	input  wire logic              launch_clock,
	// core input side
	output logic [1:0]             core_in_word,
	output logic                   core_in_valid,
	input  wire logic              core_in_ready,
	output logic                   core_in_direct,
	output logic                   bypass_input,
	// core output side
	input  wire logic [1:0]        core_out_word,
	input  wire logic              core_oe,
	// pad
	input  wire logic              pad_i,
	output logic                   pad_o,
	output logic                   pad_oe
);
	default clocking chk_cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);
	// ----------------------------------------------------------------
	// configuration decode
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] cfg_reg, cfg_next;
	dge_mode_t         mode;
	dge_ddr_t          in_ddr;
	dge_ddr_t          out_ddr;
	dge_oreg_t         oreg;
	dge_conn_t         conn;
	logic              in_reg_on, in_inv, out_inv, oe_reg_on, cfg_err;
	always_comb begin
		mode      = dge_mode_t'(cfg_reg[F_MODE_LO +: 3]);
		in_reg_on = cfg_reg[F_IN_REG];
		in_ddr    = in_reg_on ? dge_ddr_t'(cfg_reg[F_IN_DDR_LO +: 2])
		                      : DGE_DDR_NONE;
		in_inv    = in_reg_on & cfg_reg[F_IN_INV];
		oreg      = dge_oreg_t'(cfg_reg[F_OREG_LO +: 2]);
		out_ddr   = (oreg == DGE_OREG_PLAIN) ? dge_ddr_t'(cfg_reg[F_OUT_DDR_LO +: 2])
		                                     : DGE_DDR_NONE;
		out_inv   = cfg_reg[F_OUT_INV];
		oe_reg_on = cfg_reg[F_OE_REG];
		conn      = dge_conn_t'(cfg_reg[F_CONN_LO +: 3]);
		// flagged so software sees a setting the cell quietly overrides
		cfg_err   = ((oreg == DGE_OREG_INV) && (cfg_reg[F_OUT_DDR_LO +: 2] != 2'h0))
		          | (!cfg_reg[F_IN_REG] && (cfg_reg[F_IN_DDR_LO +: 2] != 2'h0));
	end

	// ----------------------------------------------------------------
	// pin synchronisers: third and second flop must agree
	// ----------------------------------------------------------------
	logic [N_LANES-1:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_d_reg;
	logic [N_LANES-1:0] filt_next;
	always_comb begin
		filt_next = filt_reg;
		for (int i = 0; i < N_LANES; i++) begin
			if (s2_reg[i] == s3_reg[i]) begin
				filt_next[i] = s3_reg[i];
			end
		end
	end
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_reg     <= '0;
			s2_reg     <= '0;
			s3_reg     <= '0;
			filt_reg   <= '0;
			filt_d_reg <= '0;
		end else begin
			s1_reg     <= {launch_clock, capture_clock, pad_i};
			s2_reg     <= s1_reg;
			s3_reg     <= s2_reg;
			filt_reg   <= filt_next;
			filt_d_reg <= filt_reg;
		end
	end
	logic pad_lvl, cap_rise, cap_fall, lau_rise, lau_fall, cap_up, cap_dn, lau_up, lau_dn;
	always_comb begin
		pad_lvl  = filt_reg[L_PAD];
		cap_up   = filt_reg[L_CAP] & ~filt_d_reg[L_CAP];
		cap_dn   = ~filt_reg[L_CAP] & filt_d_reg[L_CAP];
		lau_up   = filt_reg[L_LAUNCH] & ~filt_d_reg[L_LAUNCH];
		lau_dn   = ~filt_reg[L_LAUNCH] & filt_d_reg[L_LAUNCH];
		cap_rise = in_inv ? cap_dn : cap_up;
		cap_fall = in_inv ? cap_up : cap_dn;
		lau_rise = out_inv ? lau_dn : lau_up;
		lau_fall = out_inv ? lau_up : lau_dn;
	end
	// ----------------------------------------------------------------
	// input path
	// ----------------------------------------------------------------
	logic       rise_s_reg, rise_s_next, fall_s_reg, fall_s_next;
	logic       direct_reg, direct_next, bypass_reg, bypass_next;
	logic       push;
	logic [1:0] push_data;
	logic       buf_ready;
	logic       ovr_reg, ovr_next;
	always_comb begin
		rise_s_next = rise_s_reg;
		fall_s_next = fall_s_reg;
		push        = 1'b0;
		push_data   = 2'h0;
		if (in_reg_on && cap_rise) begin
			rise_s_next = pad_lvl;
		end
		if (in_reg_on && cap_fall && in_ddr != DGE_DDR_NONE) begin
			fall_s_next = pad_lvl;
		end
		case (in_ddr)
			DGE_DDR_NONE: begin
				push      = in_reg_on & cap_rise;
				push_data = {1'b0, pad_lvl};
			end
			DGE_DDR_NORMAL: begin
				push      = cap_rise | cap_fall;
				push_data = cap_rise ? {fall_s_reg, pad_lvl} : {pad_lvl, rise_s_reg};
			end
			DGE_DDR_REALIGN: begin
				// falling sample held half a cycle, leaves with next rising one
				push      = cap_rise;
				push_data = {fall_s_reg, pad_lvl};
			end
			default: push = 1'b0;
		endcase
		if (mode != DGE_MODE_IN && mode != DGE_MODE_BIDIR) begin
			push = 1'b0;
		end
		direct_next = 1'b0;
		bypass_next = 1'b0;
		if (mode == DGE_MODE_IN || mode == DGE_MODE_BIDIR) begin
			if (!in_reg_on) begin
				bypass_next = (conn != DGE_CONN_NORMAL) & pad_lvl;
				direct_next = (conn == DGE_CONN_NORMAL || conn == DGE_CONN_PLLREF
				            || conn == DGE_CONN_PLLFB || conn == DGE_CONN_MIPI)
				            & pad_lvl;
			end
		end
	end
	dge_buf2 #(
		.W(2)
	) u_buf (
		.ref_clk   (ref_clk),
		.arst_n    (arst_n),
		.in_valid  (push),
		.in_ready  (buf_ready),
		.in_data   (push_data),
		.out_valid (core_in_valid),
		.out_ready (core_in_ready),
		.out_data  (core_in_word)
	);
	// ----------------------------------------------------------------
	// output path
	// ----------------------------------------------------------------
	logic pad_o_reg, pad_o_next, pad_oe_reg, pad_oe_next;
	logic hold1_reg, hold1_next, oe_q_reg, oe_q_next;
	logic drive_en;
	always_comb begin
		pad_o_next = pad_o_reg;
		hold1_next = hold1_reg;
		oe_q_next  = oe_q_reg;
		if (lau_rise) begin
			oe_q_next  = core_oe;
			hold1_next = core_out_word[1];
		end
		case (oreg)
			DGE_OREG_NONE: pad_o_next = core_out_word[0];
			DGE_OREG_INV: begin
				if (lau_rise) begin
					pad_o_next = ~core_out_word[0];
				end
			end
			DGE_OREG_PLAIN: begin
				if (lau_rise) begin
					pad_o_next = core_out_word[0];
				end else if (lau_fall && out_ddr == DGE_DDR_NORMAL) begin
					pad_o_next = core_out_word[1];
				end else if (lau_fall && out_ddr == DGE_DDR_REALIGN) begin
					pad_o_next = hold1_reg;
				end
			end
			default: pad_o_next = pad_o_reg;
		endcase
		if (mode == DGE_MODE_CLKOUT) begin
			pad_o_next = filt_reg[L_LAUNCH] ^ out_inv;
		end
		drive_en = oe_reg_on ? oe_q_next : core_oe;
		case (mode)
			DGE_MODE_OUT:    pad_oe_next = 1'b1;
			DGE_MODE_CLKOUT: pad_oe_next = 1'b1;
			DGE_MODE_BIDIR:  pad_oe_next = drive_en;
			default:         pad_oe_next = 1'b0;
		endcase
	end
	// ----------------------------------------------------------------
	// register port
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] rdata_reg, rdata_next;
	always_comb begin
		cfg_next = cfg_reg;
		// a word dropped in the very cycle of the clear still counts
		ovr_next = ovr_reg;
		if (reg_wr && reg_addr == REG_CFG) begin
			cfg_next = reg_wdata;
		end
		if (reg_wr && reg_addr == REG_STAT && reg_wdata[S_OVERRUN]) begin
			ovr_next = 1'b0;
		end
		if (push && !buf_ready) begin
			ovr_next = 1'b1;
		end
		rdata_next = '0;
		if (reg_rd) begin
			case (reg_addr)
				REG_CFG:  rdata_next = cfg_reg;
				REG_STAT: rdata_next[S_FULL:S_OVERRUN] = {~buf_ready, pad_lvl, cfg_err, ovr_reg};
				REG_WORD: rdata_next[1:0] = {fall_s_reg, rise_s_reg};
				default:  rdata_next = '0;
			endcase
		end
	end
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_reg    <= CFG_RESET;
			ovr_reg    <= 1'b0;
			rdata_reg  <= '0;
			rise_s_reg <= 1'b0;
			fall_s_reg <= 1'b0;
			direct_reg <= 1'b0;
			bypass_reg <= 1'b0;
			pad_o_reg  <= 1'b0;
			pad_oe_reg <= 1'b0;
			hold1_reg  <= 1'b0;
			oe_q_reg   <= 1'b0;
		end else begin
			cfg_reg    <= cfg_next;
			ovr_reg    <= ovr_next;
			rdata_reg  <= rdata_next;
			rise_s_reg <= rise_s_next;
			fall_s_reg <= fall_s_next;
			direct_reg <= direct_next;
			bypass_reg <= bypass_next;
			pad_o_reg  <= pad_o_next;
			pad_oe_reg <= pad_oe_next;
			hold1_reg  <= hold1_next;
			oe_q_reg   <= oe_q_next;
		end
	end

	assign reg_rdata      = rdata_reg;
	assign core_in_direct = direct_reg;
	assign bypass_input   = bypass_reg;
	assign pad_o          = pad_o_reg;
	assign pad_oe         = pad_oe_reg;
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_rise_sample;
		(in_reg_on && cap_rise) |=> (rise_s_reg == $past(pad_lvl));
	endproperty
	a_rise_sample: assert property (p_rise_sample) else $error("rise sample wrong");
	property p_fall_sample;
		(in_reg_on && cap_fall && in_ddr != DGE_DDR_NONE) |=> (fall_s_reg == $past(pad_lvl));
	endproperty
	a_fall_sample: assert property (p_fall_sample) else $error("fall sample wrong");
	property p_sdr_bit1;
		(push && in_ddr == DGE_DDR_NONE) |-> (push_data[1] == 1'b0);
	endproperty
	a_sdr_bit1: assert property (p_sdr_bit1) else $error("bit one set in sdr");
	property p_realign;
		(push && in_ddr == DGE_DDR_REALIGN && !core_in_valid)
		|=> core_in_valid && (core_in_word == {$past(fall_s_reg), $past(pad_lvl)});
	endproperty
	a_realign: assert property (p_realign) else $error("realign word wrong");
	property p_launch_fall;
		(mode == DGE_MODE_OUT && out_ddr == DGE_DDR_NORMAL && lau_fall && !lau_rise)
		|=> (pad_o_reg == $past(core_out_word[1]));
	endproperty
	a_launch_fall: assert property (p_launch_fall) else $error("fall launch wrong");
	property p_inv_reg;
		(mode == DGE_MODE_OUT && oreg == DGE_OREG_INV && lau_rise)
		|=> (pad_o_reg == !$past(core_out_word[0]));
	endproperty
	a_inv_reg: assert property (p_inv_reg) else $error("inverted launch wrong");
	property p_oe_follow;
		(mode == DGE_MODE_BIDIR && !oe_reg_on) |=> (pad_oe_reg == $past(core_oe));
	endproperty
	a_oe_follow: assert property (p_oe_follow) else $error("enable not followed");
	property p_oe_idle;
		(mode == DGE_MODE_IN || mode == DGE_MODE_UNUSED) |=> !pad_oe_reg;
	endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("driver on as input");
	property p_bypass_off;
		in_reg_on |=> !bypass_reg;
	endproperty
	a_bypass_off: assert property (p_bypass_off) else $error("bypass while registered");
	property p_pll_core;
		(mode == DGE_MODE_IN && !in_reg_on && conn == DGE_CONN_PLLREF)
		|=> (direct_reg == $past(pad_lvl)) && (bypass_reg == $past(pad_lvl));
	endproperty
	a_pll_core: assert property (p_pll_core) else $error("pll input not on core");
	c_realign: cover property (push && in_ddr == DGE_DDR_REALIGN && push_data == 2'h2);
	c_fall_launch: cover property (lau_fall && out_ddr == DGE_DDR_NORMAL);
	c_full: cover property (push && !buf_ready);
endmodule : dge_cell

// ---- dge_fabric_model.sv ----
// ----------------------------------------------------------------
// fabric and pad model: slow core clocks, pad driver, core consumer
// ----------------------------------------------------------------
module dge_fabric_model #(
	parameter int HALF = 8
) (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       arst_n,
	// bench control
	input  wire logic       run_cap,
	input  wire logic       run_launch,
	input  wire logic [1:0] pat,
	input  wire logic       ext_drive,
	input  wire logic       stall,
	// fabric clocks
	output logic            capture_clock,
	output logic            launch_clock,
	// core input side
	input  wire logic [1:0] core_in_word,
	input  wire logic       core_in_valid,
	output logic            core_in_ready,
	// pad
	input  wire logic       pad_o,
	input  wire logic       pad_oe,
	output logic            pad_i
);
	logic [1:0] got[$];
	int         cap_cnt;
	int         lau_cnt;
	logic       ext_val;

	// weak pull-up holds the pad when nobody drives it
	assign pad_i = pad_oe ? pad_o : (ext_drive ? ext_val : 1'b1);
	assign core_in_ready = !stall;

	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cap_cnt <= 0;
			lau_cnt <= 3;
			capture_clock <= 1'b0;
			launch_clock <= 1'b0;
			ext_val <= 1'b1;
		end else begin
			if (run_cap) begin
				cap_cnt <= (cap_cnt == HALF - 1) ? 0 : cap_cnt + 1;
				if (cap_cnt == HALF - 1) capture_clock <= !capture_clock;
				// data moves mid-phase, well clear of both edges
				if (cap_cnt == HALF / 2) ext_val <= capture_clock ? pat[1] : pat[0];
			end else begin
				ext_val <= pat[0];
			end
			// own counter: launch timing is independent of capture
			if (run_launch) begin
				lau_cnt <= (lau_cnt == HALF - 1) ? 0 : lau_cnt + 1;
				if (lau_cnt == HALF - 1) launch_clock <= !launch_clock;
			end
			if (core_in_valid && !stall) got.push_back(core_in_word);
		end
	end
endmodule : dge_fabric_model

// ---- dge_cell_tb.sv ----
module dge_cell_tb
	import dge_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic              ref_clk = 1'b0;
	logic              arst_n = 1'b0;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic              reg_wr = 1'b0;
	logic              reg_rd = 1'b0;
	logic [DATA_W-1:0] reg_rdata;
	logic              capture_clock;
	logic              launch_clock;
	logic [1:0]        core_in_word;
	logic              core_in_valid;
	logic              core_in_ready;
	logic              core_in_direct;
	logic              bypass_input;
	logic [1:0]        core_out_word = 2'h0;
	logic              core_oe = 1'b0;
	logic              pad_i;
	logic              pad_o;
	logic              pad_oe;
	logic              run_cap = 1'b0;
	logic              run_launch = 1'b0;
	logic [1:0]        pat = 2'h1;
	logic              ext_drive = 1'b1;
	logic              stall = 1'b0;
	int                n_errors = 0;
	int                cmp_count = 0;
	logic [31:0]       d;
	// input rows: dual-edge mode, capture invert, pad pattern, word, pushes a period
	logic [1:0]        r_dd[4] = '{2'h0, 2'h0, 2'h1, 2'h2};
	logic              r_ci[4] = '{1'b0, 1'b1, 1'b0, 1'b0};
	logic [1:0]        r_pat[4] = '{2'h1, 2'h2, 2'h2, 2'h2};
	logic [1:0]        r_w[4] = '{2'h1, 2'h1, 2'h2, 2'h2};
	int                r_n[4] = '{1, 1, 2, 1};

	always #5 ref_clk = ~ref_clk;

	dge_cell uut (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.capture_clock(capture_clock), .launch_clock(launch_clock),
		.core_in_word(core_in_word), .core_in_valid(core_in_valid),
		.core_in_ready(core_in_ready), .core_in_direct(core_in_direct),
		.bypass_input(bypass_input), .core_out_word(core_out_word), .core_oe(core_oe),
		.pad_i(pad_i), .pad_o(pad_o), .pad_oe(pad_oe));

	dge_fabric_model model (.ref_clk(ref_clk), .arst_n(arst_n), .run_cap(run_cap),
		.run_launch(run_launch), .pat(pat), .ext_drive(ext_drive), .stall(stall),
		.capture_clock(capture_clock), .launch_clock(launch_clock),
		.core_in_word(core_in_word), .core_in_valid(core_in_valid),
		.core_in_ready(core_in_ready), .pad_o(pad_o), .pad_oe(pad_oe), .pad_i(pad_i));

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : idle

	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// data stand only in the cycle after the strobe, so sample just past that edge
	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
		@(posedge ref_clk);
	endtask : rd

	// waits for a fresh edge, so a level already standing is not taken as one
	task automatic wait_launch(input logic lvl);
		logic prev;
		prev = launch_clock;
		for (int i = 0; i <= 64; i++) begin
			@(posedge ref_clk);
			if (launch_clock === lvl && prev !== lvl) break;
			prev = launch_clock;
			if (i == 64) begin
				n_errors++;
				$display("ERROR launch clock expected %h seen stuck", lvl);
				complete_run();
			end
		end
	endtask : wait_launch

	function automatic logic [31:0] cfgw(input logic [2:0] m, input logic ir,
		input logic [1:0] dd, input logic ci, input logic [1:0] orr, input logic [1:0] od,
		input logic oer, input logic [2:0] cn);
		return {16'h0, cn, oer, 1'b0, od, orr, ci, dd, ir, m};
	endfunction : cfgw

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		idle(10);
		arst_n <= 1'b1;
		@(posedge ref_clk);
		rd(REG_CFG, d);
		chk("cfg reset", 32'h0000_0004, d);
		wr(4'hc, 32'hffff_ffff);
		rd(4'hc, d);
		chk("unmapped read", 32'h0, d);
		rd(REG_CFG, d);
		chk("cfg after unmapped write", 32'h0000_0004, d);
		$display("test registers done");

		for (int m = 0; m < 5; m++) begin
			wr(REG_CFG, cfgw(m[2:0], 1'b0, 2'h0, 1'b0, 2'h0, 2'h0, 1'b0, 3'h0));
			idle(4);
			chk("pad enable by mode", {31'h0, m == 1 || m == 3}, {31'h0, pad_oe});
		end
		$display("test modes done");

		for (int i = 0; i < 4; i++) begin
			pat <= r_pat[i];
			wr(REG_CFG, cfgw(3'h0, 1'b1, r_dd[i], r_ci[i], 2'h0, 2'h0, 1'b0, 3'h0));
			run_cap <= 1'b1;
			idle(48);
			model.got.delete();
			idle(64);
			d = model.got.size();
			chk("push count", 32'h1, {31'h0, d >= 4 * r_n[i] - 1 && d <= 4 * r_n[i] + 1});
			chk("input word", {30'h0, r_w[i]}, {30'h0, model.got[$]});
		end
		rd(REG_WORD, d);
		chk("sample word", 32'h2, d);
		$display("test input capture done");

		stall <= 1'b1;
		wr(REG_CFG, cfgw(3'h0, 1'b1, 2'h1, 1'b0, 2'h0, 2'h0, 1'b0, 3'h0));
		model.got.delete();
		idle(64);
		run_cap <= 1'b0;
		rd(REG_STAT, d);
		chk("overrun and full", 32'h9, d & 32'h9);
		wr(REG_STAT, 32'h1);
		rd(REG_STAT, d);
		chk("overrun cleared", 32'h8, d & 32'h9);
		stall <= 1'b0;
		idle(6);
		chk("words kept", 32'h2, model.got.size());
		chk("buffer drained", 32'h0, {31'h0, core_in_valid});
		$display("test buffer done");

		for (int cn = 0; cn < 6; cn++) begin
			wr(REG_CFG, cfgw(3'h0, 1'b0, 2'h0, 1'b0, 2'h0, 2'h0, 1'b0, cn[2:0]));
			for (int v = 1; v >= 0; v--) begin
				pat <= v[1:0];
				idle(8);
				chk("bypass input", {31'h0, v == 1 && cn != 0}, {31'h0, bypass_input});
				chk("direct input", {31'h0, v == 1 && (cn == 0 || cn >= 3)}, {31'h0, core_in_direct});
			end
		end
		pat <= 2'h1;
		wr(REG_CFG, cfgw(3'h0, 1'b1, 2'h0, 1'b0, 2'h0, 2'h0, 1'b0, 3'h1));
		idle(8);
		chk("bypass when registered", 32'h0, {31'h0, bypass_input});
		$display("test bypass done");

		core_out_word <= 2'h1;
		run_launch <= 1'b1;
		wr(REG_CFG, cfgw(3'h1, 1'b0, 2'h0, 1'b0, 2'h1, 2'h1, 1'b0, 3'h0));
		rd(REG_STAT, d);
		chk("no cfg error", 32'h0, d & 32'h2);
		for (int k = 0; k < 2; k++) begin
			wait_launch(1'b1);
			idle(6);
			chk("pad rise bit", {31'h0, k == 0}, {31'h0, pad_o});
			wait_launch(1'b0);
			idle(6);
			chk("pad fall bit", 32'h0, {31'h0, pad_o});
			// second pass: inverted register, dual-edge must be dropped
			core_out_word <= 2'h3;
			wr(REG_CFG, cfgw(3'h1, 1'b0, 2'h0, 1'b0, 2'h2, 2'h1, 1'b0, 3'h0));
		end
		rd(REG_STAT, d);
		chk("cfg error flag", 32'h2, d & 32'h2);
		// realign: bit one is taken at the rise, so a later change must not reach the pad
		core_out_word <= 2'h2;
		wr(REG_CFG, cfgw(3'h1, 1'b0, 2'h0, 1'b0, 2'h1, 2'h2, 1'b0, 3'h0));
		wait_launch(1'b1);
		idle(6);
		chk("realign rise bit", 32'h0, {31'h0, pad_o});
		core_out_word <= 2'h0;
		wait_launch(1'b0);
		idle(6);
		chk("realign fall bit", 32'h1, {31'h0, pad_o});
		$display("test output done");

		wr(REG_CFG, cfgw(3'h2, 1'b0, 2'h0, 1'b0, 2'h0, 2'h0, 1'b0, 3'h0));
		idle(4);
		chk("bidir released", 32'h0, {31'h0, pad_oe});
		core_oe <= 1'b1;
		idle(3);
		chk("bidir driving", 32'h1, {31'h0, pad_oe});
		core_oe <= 1'b0;
		wr(REG_CFG, cfgw(3'h2, 1'b0, 2'h0, 1'b0, 2'h1, 2'h0, 1'b1, 3'h0));
		idle(40);
		run_launch <= 1'b0;
		// let a launch edge still in the synchroniser pass before the enable moves
		idle(8);
		core_oe <= 1'b1;
		idle(16);
		chk("enable held without launch", 32'h0, {31'h0, pad_oe});
		run_launch <= 1'b1;
		idle(40);
		chk("enable after launch", 32'h1, {31'h0, pad_oe});
		$display("test bidir done");
		complete_run();
	end
endmodule : dge_cell_tb
